//--- rtl/ufpc_pkg.sv
// package: register map, codes and timing for the user-mode flash program control
package ufpc_pkg;
  localparam logic [7:0] UFPC_OFF_KEY = 8'h00;
  localparam logic [7:0] UFPC_OFF_CTRL = 8'h04;
  localparam logic [7:0] UFPC_OFF_SECH = 8'h08;
  localparam logic [7:0] UFPC_OFF_SECL = 8'h0c;
  localparam logic [7:0] UFPC_OFF_STAT = 8'h10;
  localparam logic [7:0] UFPC_KEY_OPEN = 8'ha5;
  localparam logic [7:0] UFPC_KEY_RESET = 8'h00;
  localparam logic [7:0] UFPC_CTRL_RESET = 8'h00;
  localparam logic [6:0] UFPC_CODE_PROG = 7'h28;
  localparam logic [3:0] UFPC_NIB_LOCK = 4'h6;
  localparam logic [3:0] UFPC_NIB_ERASE = 4'ha;
  localparam logic [7:0] UFPC_SECL_MASK = 8'h80;
  localparam int UFPC_CLK_HZ = 20000000;
  localparam int UFPC_ERASE_US = 4000;
  localparam int UFPC_PROG_US = 20;
  localparam int UFPC_ERASE_CYC = UFPC_ERASE_US * (UFPC_CLK_HZ / 1000000);
  localparam int UFPC_PROG_CYC = UFPC_PROG_US * (UFPC_CLK_HZ / 1000000);
  typedef enum logic [1:0] {
    UFPC_IDLE = 2'b00,
    UFPC_PROG = 2'b01,
    UFPC_ERASE = 2'b10,
    UFPC_LOCK = 2'b11
  } ufpc_state_e;
endpackage : ufpc_pkg

//--- rtl/ufpc_array.sv
// flash array model: 8-bit words, registered read, write and sector erase
`timescale 1ns/1ps
module ufpc_array #(
  parameter int AW = 13
) (
  input wire logic clock_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  input wire logic erase_in,
  input wire logic [AW-8:0] sector_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clock_in) begin
    if (erase_in) begin
      for (int i = 0; i < 128; i++) begin
        mem[{sector_in, i[6:0]}] <= 8'hff;
      end
    end else if (wr_in) begin
      // flash bits only go from one to zero
      mem[addr_in] <= mem[addr_in] & wdata_in;
    end
    rdata_out <= mem[addr_in];
  end
endmodule : ufpc_array

//--- rtl/ufpc_ctrl.sv
// user-mode flash program control with apb registers and cpu load/store port
//
// Functional notes
// - flash is written one byte per store; software erases the sector first.
// - control 0101000x selects byte programming; bit 0 is ignored there.
// - a store programs the byte at its 16-bit address with its data.
// - a load returns the flash byte at its address, with no setup.
// - upper control nibble 0110 selects hard-lock protection.
// - control 01100001 with writes unlocked engages hard lock.
// - once hard-locked, every program or erase is refused.
// - hard lock clears only by tool-mode chip erase, not by reset.
// - key reads zero after reset; writes unlocked only when key is a5.
// - sector base is 128-byte aligned; low bits 6..0 ignored.
// - start bit runs erase or lock, stalls the cpu, then self-clears; the code stalls the cpu during erase only, not during lock.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module ufpc_ctrl
  import ufpc_pkg::*;
#(
  parameter int AW = 13,
  parameter int ERASE_CYC = UFPC_ERASE_CYC,
  parameter int PROG_CYC = UFPC_PROG_CYC
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic mem_req_in,
  input wire logic mem_we_in,
  input wire logic [15:0] flash_addr_reg_pair_in,
  input wire logic [7:0] mem_wdata_in,
  output logic [7:0] mem_rdata_out,
  output logic mem_ack_out,
  output logic cpu_stall_out,
  input wire logic tool_chip_erase_in,
  output logic hard_lock_out
);
  logic [7:0] flash_write_key, next_flash_write_key;
  logic [7:0] flash_op_control, next_flash_op_control;
  logic [7:0] sector_addr_high, next_sector_addr_high;
  logic [7:0] sector_addr_low, next_sector_addr_low;
  logic hard_lock, next_hard_lock;
  ufpc_state_e state, next_state;
  logic [31:0] count, next_count;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [7:0] next_mem_rdata;
  logic next_mem_ack, rd_pend, next_rd_pend;
  logic arr_wr, arr_erase;
  logic [7:0] arr_rdata;
  logic unlocked, in_sector, prog_mode, apb_acc;
  logic [8:0] sector_base;

  function automatic logic [31:0] ufpc_rd(input logic [7:0] a, input logic [7:0] k,
      input logic [7:0] c, input logic [7:0] h, input logic [7:0] l, input logic hl,
      input logic [1:0] st);
    case (a)
      UFPC_OFF_KEY: ufpc_rd = {24'h000000, k};
      UFPC_OFF_CTRL: ufpc_rd = {24'h000000, c};
      UFPC_OFF_SECH: ufpc_rd = {24'h000000, h};
      UFPC_OFF_SECL: ufpc_rd = {24'h000000, l & UFPC_SECL_MASK};
      UFPC_OFF_STAT: ufpc_rd = {29'h00000000, st, hl};
      default: ufpc_rd = 32'h00000000;
    endcase
  endfunction : ufpc_rd

  assign unlocked = (flash_write_key == UFPC_KEY_OPEN);
  assign prog_mode = (flash_op_control[7:1] == UFPC_CODE_PROG);
  // sector base from both address registers; only bit 7 of the low byte counts
  assign sector_base = {sector_addr_high, sector_addr_low[7]};
  assign in_sector = (sector_base == flash_addr_reg_pair_in[15:7]);
  assign apb_acc = psel_in && penable_in && !pready_out;

  always_comb begin
    next_flash_write_key = flash_write_key;
    next_flash_op_control = flash_op_control;
    next_sector_addr_high = sector_addr_high;
    next_sector_addr_low = sector_addr_low;
    next_hard_lock = hard_lock;
    next_state = state;
    next_count = count;
    next_prdata = prdata_out;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_mem_rdata = mem_rdata_out;
    next_mem_ack = 1'b0;
    next_rd_pend = 1'b0;
    arr_wr = 1'b0;
    arr_erase = 1'b0;
    // register access is answered one cycle into the access phase
    if (apb_acc) begin
      next_pready = 1'b1;
      if (pwrite_in) begin
        case (paddr_in)
          UFPC_OFF_KEY: next_flash_write_key = pwdata_in[7:0];
          UFPC_OFF_CTRL: next_flash_op_control = pwdata_in[7:0];
          UFPC_OFF_SECH: next_sector_addr_high = pwdata_in[7:0];
          UFPC_OFF_SECL: next_sector_addr_low = pwdata_in[7:0] & UFPC_SECL_MASK;
          UFPC_OFF_STAT: next_pslverr = 1'b0;
          default: next_pslverr = 1'b1;
        endcase
      end else begin
        next_prdata = ufpc_rd(paddr_in, flash_write_key, flash_op_control, sector_addr_high,
                              sector_addr_low, hard_lock, state);
        next_pslverr = (paddr_in > UFPC_OFF_STAT) || (paddr_in[1:0] != 2'b00);
      end
    end
    case (state)
      UFPC_IDLE: begin
        // start bit stays pending while the key is closed, as the hardware leaves it high
        if (flash_op_control[0] && unlocked && !prog_mode) begin
          if (flash_op_control[7:4] == UFPC_NIB_LOCK) begin
            next_state = UFPC_LOCK;
            next_count = 32'd0;
          end else if (flash_op_control[7:4] == UFPC_NIB_ERASE && !hard_lock) begin
            next_state = UFPC_ERASE;
            next_count = 32'd0;
          end else begin
            next_flash_op_control[0] = 1'b0;
          end
        end else if (mem_req_in && !rd_pend && !mem_ack_out) begin
          if (!mem_we_in) begin
            next_rd_pend = 1'b1;
          end else if (unlocked && prog_mode && in_sector && !hard_lock) begin
            arr_wr = 1'b1;
            next_state = UFPC_PROG;
            next_count = 32'd0;
          end else begin
            next_mem_ack = 1'b1;
          end
        end
        if (rd_pend) begin
          next_mem_rdata = arr_rdata;
          next_mem_ack = 1'b1;
        end
      end
      UFPC_PROG: begin
        next_count = count + 32'd1;
        if (count >= PROG_CYC - 1) begin
          next_state = UFPC_IDLE;
          next_mem_ack = 1'b1;
        end
      end
      UFPC_ERASE: begin
        next_count = count + 32'd1;
        if (count >= ERASE_CYC - 1) begin
          arr_erase = 1'b1;
          next_state = UFPC_IDLE;
          next_flash_op_control[0] = 1'b0;
        end
      end
      UFPC_LOCK: begin
        next_hard_lock = 1'b1;
        next_state = UFPC_IDLE;
        next_flash_op_control[0] = 1'b0;
      end
      default: next_state = UFPC_IDLE;
    endcase
    if (tool_chip_erase_in) begin
      next_hard_lock = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flash_write_key <= UFPC_KEY_RESET;
      flash_op_control <= UFPC_CTRL_RESET;
      sector_addr_high <= 8'h00;
      sector_addr_low <= 8'h00;
      state <= UFPC_IDLE;
      count <= 32'd0;
      prdata_out <= 32'h00000000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      mem_rdata_out <= 8'h00;
      mem_ack_out <= 1'b0;
      rd_pend <= 1'b0;
    end else begin
      flash_write_key <= next_flash_write_key;
      flash_op_control <= next_flash_op_control;
      sector_addr_high <= next_sector_addr_high;
      sector_addr_low <= next_sector_addr_low;
      state <= next_state;
      count <= next_count;
      prdata_out <= next_prdata;
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
      mem_rdata_out <= next_mem_rdata;
      mem_ack_out <= next_mem_ack;
      rd_pend <= next_rd_pend;
    end
  end

  // lock is non-volatile: no reset branch, only tool chip erase clears it
  always_ff @(posedge clock_in) begin
    hard_lock <= next_hard_lock;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cpu_stall_out <= 1'b0;
      hard_lock_out <= 1'b0;
    end else begin
      cpu_stall_out <= (next_state == UFPC_PROG) || (next_state == UFPC_ERASE);
      hard_lock_out <= next_hard_lock;
    end
  end

  ufpc_array #(
    .AW(AW)
  ) u_array (
    .clock_in(clock_in),
    .addr_in(flash_addr_reg_pair_in[AW-1:0]),
    .wr_in(arr_wr),
    .wdata_in(mem_wdata_in),
    .erase_in(arr_erase),
    .sector_in(sector_base[AW-8:0]),
    .rdata_out(arr_rdata)
  );
endmodule : ufpc_ctrl

//--- verif/ufpc_ctrl_monitor.sv
// checker: port-level timing properties of the flash program control
`timescale 1ns/1ps
module ufpc_ctrl_monitor (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic mem_req_in,
  input wire logic mem_we_in,
  input wire logic mem_ack_out,
  input wire logic cpu_stall_out,
  input wire logic tool_chip_erase_in,
  input wire logic hard_lock_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_apb_answer: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("apb answer late");
  a_err_with_ready: assert property (pslverr_out |-> pready_out) else $error("lone error");
  a_load_ack_two: assert property ($rose(mem_req_in) && !mem_we_in && !cpu_stall_out |-> ##2 mem_ack_out)
    else $error("load answer late");
  a_ack_one_cycle: assert property (mem_ack_out |=> !mem_ack_out) else $error("ack too long");
  a_stall_bounded: assert property ($rose(cpu_stall_out) |-> cpu_stall_out[*2] ##[1:40] !cpu_stall_out)
    else $error("stall length wrong");
  a_stall_ends_ack: assert property ($fell(cpu_stall_out) && mem_req_in && mem_we_in |-> mem_ack_out)
    else $error("store released without ack");
  a_lock_refuses: assert property ($rose(mem_req_in) && mem_we_in && hard_lock_out && !cpu_stall_out
    |=> mem_ack_out && !cpu_stall_out) else $error("locked store not refused");
  a_lock_sticky: assert property (hard_lock_out && !tool_chip_erase_in |=> hard_lock_out)
    else $error("lock dropped");
  a_lock_tool_clear: assert property (tool_chip_erase_in |=> !hard_lock_out)
    else $error("tool erase left lock");
  cover property ($rose(hard_lock_out));
  cover property ($fell(cpu_stall_out) && mem_ack_out);
  cover property (pslverr_out);
endmodule : ufpc_ctrl_monitor
bind ufpc_ctrl ufpc_ctrl_monitor mon (.clock_in, .rst_n_in, .psel_in, .penable_in, .pready_out,
  .pslverr_out, .mem_req_in, .mem_we_in, .mem_ack_out, .cpu_stall_out, .tool_chip_erase_in,
  .hard_lock_out);

//--- verif/ufpc_cpu_model.sv
// cpu-side model issuing program-memory load and store cycles
`timescale 1ns/1ps
module ufpc_cpu_model (
  input wire logic clock_in,
  input wire logic mem_ack_in,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [15:0] addr_out,
  output logic [7:0] wdata_out
);
  initial {mem_req_out, mem_we_out, addr_out, wdata_out} = '0;
  // raised when a request never saw its acknowledge; the bench ends the run on it
  bit timed_out = 1'b0;
  // one byte per request: address from the register pair, data from a working register
  task automatic access(input logic we, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    mem_req_out <= 1'b1;
    mem_we_out <= we;
    addr_out <= a;
    wdata_out <= d;
    do begin
      @(posedge clock_in);
      n++;
    end while (!mem_ack_in && n < 2000);
    if (!mem_ack_in) timed_out = 1'b1;
    mem_req_out <= 1'b0;
    // released lines show garbage so a stale address cannot pass
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask : access
endmodule : ufpc_cpu_model

//--- verif/ufpc_ctrl_tb.sv
// self-checking bench for the flash program control
`timescale 1ns/1ps
module ufpc_ctrl_tb;
  import ufpc_pkg::*;
  logic clock_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic tool_chip_erase_in = 1;
  logic [7:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0;
  wire logic [31:0] prdata_out;
  wire logic pready_out, pslverr_out, mem_req_in, mem_we_in, mem_ack_out, cpu_stall_out;
  wire logic hard_lock_out;
  wire logic [15:0] flash_addr_reg_pair_in;
  wire logic [7:0] mem_wdata_in, mem_rdata_out;
  logic [32:0] qa[$];
  logic [7:0] qm[$];
  int n_fail = 0, total_checks = 0;
  bit hung = 1'b0;
  localparam int ER_CYC = 20;
  logic [7:0] d;
  logic [15:0] a;
  initial forever #25 clock_in = ~clock_in;
  ufpc_ctrl #(.ERASE_CYC(ER_CYC), .PROG_CYC(4)) uut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .mem_req_in(mem_req_in), .mem_we_in(mem_we_in),
    .flash_addr_reg_pair_in(flash_addr_reg_pair_in), .mem_wdata_in(mem_wdata_in),
    .mem_rdata_out(mem_rdata_out), .mem_ack_out(mem_ack_out), .cpu_stall_out(cpu_stall_out),
    .tool_chip_erase_in(tool_chip_erase_in), .hard_lock_out(hard_lock_out));
  ufpc_cpu_model cpu (.clock_in, .mem_ack_in(mem_ack_out), .mem_req_out(mem_req_in),
    .mem_we_out(mem_we_in), .addr_out(flash_addr_reg_pair_in), .wdata_out(mem_wdata_in));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] v, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge clock_in);
    qa.push_back(e);
    {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, ad, v};
    @(posedge clock_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (!pready_out && n < 50);
    if (!pready_out) hung = 1'b1;
    {psel_in, penable_in} <= 2'b00;
  endtask : apb
  task automatic wr(input logic [7:0] ad, input logic [7:0] v, input logic e);
    apb(1'b1, ad, {24'h0, v}, {e, 32'h0});
  endtask : wr
  task automatic rc(input logic [7:0] ad, input logic [7:0] v, input logic e);
    apb(1'b0, ad, 32'h0, {e, 24'h0, v});
  endtask : rc
  task automatic ld(input logic [15:0] ad, input logic [7:0] v);
    qm.push_back(v);
    cpu.access(1'b0, ad, 8'h00);
  endtask : ld
  // counts the edges at which the cpu is seen stalled, bounded
  task automatic stall_wait(input int e);
    int n;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (cpu_stall_out && n < 100);
    if (cpu_stall_out) hung = 1'b1;
    chk("erase_stall", 32'(n - 1), 32'(e));
  endtask : stall_wait
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  always @(posedge clock_in) begin
    if (pready_out) begin
      chk("apb_error", 32'(pslverr_out), 32'(qa[0][32]));
      if (!pwrite_in && !qa[0][32]) chk("prdata", prdata_out, qa[0][31:0]);
      void'(qa.pop_front());
    end
    if (mem_ack_out && !mem_we_in) chk("load", 32'(mem_rdata_out), 32'(qm.pop_front()));
  end
  always @(posedge clock_in) begin
    if (hung || cpu.timed_out) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    #2000000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    d = 8'($urandom(32'hcce9));
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    tool_chip_erase_in <= 1'b0;
    rc(UFPC_OFF_KEY, 8'h00, 1'b0);
    wr(UFPC_OFF_KEY, UFPC_KEY_OPEN, 1'b0);
    wr(UFPC_OFF_SECH, 8'h01, 1'b0);
    wr(UFPC_OFF_SECL, 8'h7f, 1'b0);
    rc(UFPC_OFF_SECL, 8'h00, 1'b0);
    wr(UFPC_OFF_CTRL, 8'ha1, 1'b0);
    stall_wait(ER_CYC);
    rc(UFPC_OFF_CTRL, 8'ha0, 1'b0);
    ld(16'h0105, 8'hff);
    wr(UFPC_OFF_CTRL, 8'h51, 1'b0);
    d = 8'($urandom);
    a = 16'h0100 + 16'($urandom_range(126));
    cpu.access(1'b1, a, d);
    wr(UFPC_OFF_SECL, 8'h80, 1'b0);
    cpu.access(1'b1, a + 16'h1, 8'h00);
    wr(UFPC_OFF_SECL, 8'h00, 1'b0);
    wr(UFPC_OFF_KEY, 8'h00, 1'b0);
    cpu.access(1'b1, a + 16'h1, 8'h00);
    ld(a, d);
    ld(a + 16'h1, 8'hff);
    wr(UFPC_OFF_KEY, UFPC_KEY_OPEN, 1'b0);
    wr(UFPC_OFF_CTRL, 8'h61, 1'b0);
    wr(UFPC_OFF_KEY, 8'h00, 1'b0);
    rc(UFPC_OFF_STAT, 8'h01, 1'b0);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rc(UFPC_OFF_STAT, 8'h01, 1'b0);
    chk("hard_lock", 32'(hard_lock_out), 32'h1);
    rc(UFPC_OFF_KEY, 8'h00, 1'b0);
    wr(UFPC_OFF_KEY, UFPC_KEY_OPEN, 1'b0);
    wr(UFPC_OFF_CTRL, 8'h50, 1'b0);
    wr(UFPC_OFF_SECH, 8'h01, 1'b0);
    cpu.access(1'b1, a + 16'h1, 8'h00);
    ld(a + 16'h1, 8'hff);
    rc(8'h14, 8'h00, 1'b1);
    wr(8'h20, 8'h5a, 1'b1);
    tool_chip_erase_in <= 1'b1;
    @(posedge clock_in);
    tool_chip_erase_in <= 1'b0;
    rc(UFPC_OFF_STAT, 8'h00, 1'b0);
    chk("hard_lock", 32'(hard_lock_out), 32'h0);
    chk("loads_left", 32'(qm.size()), 32'h0);
    tally_and_finish();
  end
endmodule : ufpc_ctrl_tb
